// [rtl/stp_pkg.sv]
// package for the serializer tap and polarity register slice
package stp_pkg;
    // register map (device address and register offsets)
    localparam logic [4:0] STP_DEV_ADDR = 5'h1E;
    localparam logic [15:0] STP_LINE_CTRL_OFS = 16'h0005;
    localparam logic [15:0] STP_HOST_CTRL_OFS = 16'h0006;
    localparam logic [15:0] STP_PWR_CTRL_OFS = 16'h0001;
    // reset values
    localparam logic [15:0] STP_LINE_CTRL_RST = 16'h2000;
    localparam logic [15:0] STP_HOST_CTRL_RST = 16'hF115;
    // bit positions and lane count
    localparam int STP_PD_BIT = 15;
    localparam int STP_PLL_ON_BIT = 4;
    localparam int STP_LANES = 4;
    // tap codes: sign bit position of the five-bit and of the four-bit codes
    localparam int STP_POST1_SIGN_BIT = 4;
    localparam int STP_SHORT_SIGN_BIT = 3;

    // line-side control word layout
    typedef struct packed {
        logic lineRxPairSwap;
        logic lineTxPairSwap;
        logic reservedOne;
        logic [4:0] firstPostTapCode;
        logic [3:0] preTapCode;
        logic [3:0] secondPostTapCode;
    } stp_line_ctrl_type;

    // host-side control word layout
    typedef struct packed {
        logic [3:0] hostLaneWriteMask;
        logic [1:0] reservedHi;
        logic [1:0] hostPllBwSelect;
        logic [2:0] reservedLo;
        logic hostPllOn;
        logic [3:0] hostPllMultiplier;
    } stp_host_ctrl_type;

    // decoded signed tap weight: sign plus magnitude in 2.5 percent steps
    typedef struct packed {
        logic negative;
        logic [3:0] steps;
    } stp_tap_type;

    // management register access
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [4:0] devAddr;
        logic [15:0] regAddr;
        logic [15:0] wrData;
    } stp_mgmt_req_type;
endpackage

// [rtl/stp_regs.sv]
// register slice: line-side tap/polarity word and host-side PLL/lane word
// Overview of operation
// - bit 15 swaps receive pair polarity
// - bit 14 swaps transmit pair polarity
// - bit 13 reserved, read/write, resets one
// - bits 12:8 first post tap code
// - first post code: sign plus four-bit magnitude
// - bits 7:4 pre tap code
// - pre code: sign plus three-bit magnitude
// - bits 3:0 second post tap code
// - second post code decoded same way
// - host word at 0x0006, resets 0xF115
// - line word at 0x0005, resets 0x2000
// - lane mask gates per-lane writes, reads back as written
// - pll forced off by pin or bit
`timescale 1ns/100ps
module stp_regs
    import stp_pkg::*;
#(
    parameter int LANES = STP_LANES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // management access from the serial station logic
    input wire stp_mgmt_req_type mgmtReq,
    output logic [15:0] mgmtRdData,
    output logic mgmtRdValid,
    // power controls: pin, and the power-down bit of register 0x0001
    input wire logic channelPowerdownLow,
    input wire logic [15:0] pwrCtrlWord,
    // raw line data in both directions
    input wire logic lineRxRaw,
    output logic lineRxData,
    input wire logic lineTxData,
    output logic lineTxPos,
    output logic lineTxNeg,
    // decoded transmit tap weights
    output stp_tap_type firstPostTap,
    output stp_tap_type preTap,
    output stp_tap_type secondPostTap,
    // host-side pll controls and lane write mask
    output logic hostPllEnable,
    output logic [1:0] hostPllBwSelect,
    output logic [3:0] hostPllMultiplier,
    output logic [LANES-1:0] hostLaneWriteMask
);
    stp_line_ctrl_type lineCtrl; // line-side word, taps and pair swaps
    stp_host_ctrl_type hostCtrl; // host-side word, pll and lane mask
    logic pdSync1; // first stage, read only by pdSync2
    logic pdSync2; // synchronised power-down pin, high while running
    logic rxSync1; // first stage of receive sampler
    logic rxSync2; // synchronised receive data
    logic devHit; // access addresses this device
    logic lineHit; // access aims at the line-side word
    logic hostHit; // access aims at the host-side word
    logic lineWr; // write strobe for the line-side word
    logic hostWr; // write strobe for the host-side word
    logic pllForcedOff; // either power-down source is active
    logic [15:0] next_rdData; // read mux result

    // address decode; only a full device and register match selects a word
    assign devHit = (mgmtReq.devAddr == STP_DEV_ADDR);
    assign lineHit = devHit && (mgmtReq.regAddr == STP_LINE_CTRL_OFS);
    assign hostHit = devHit && (mgmtReq.regAddr == STP_HOST_CTRL_OFS);
    // a write to any other offset or device falls through untouched
    assign lineWr = mgmtReq.wrEn && lineHit;
    assign hostWr = mgmtReq.wrEn && hostHit;

    // power-down sources; the pin has already passed two flops here
    assign pllForcedOff = !pdSync2 || pwrCtrlWord[STP_PD_BIT];

    // line-side word: plain storage, every field returns what was written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // reserved bit comes back up as one, the taps as zero
            lineCtrl <= STP_LINE_CTRL_RST;
        end else if (lineWr) begin
            // reserved bit kept as written; software should keep it one
            lineCtrl <= stp_line_ctrl_type'(mgmtReq.wrData);
        end
    end

    // host-side word: mask is a plain field of this word, so it always updates;
    // the gating it does belongs to the per-lane registers outside this slice
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hostCtrl <= STP_HOST_CTRL_RST;
        end else if (hostWr) begin
            hostCtrl <= stp_host_ctrl_type'(mgmtReq.wrData);
        end
    end

    // power-down pin synchroniser, two stages before any use;
    // resets to the powered-down side so the pll starts off until the pin is seen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pdSync1 <= 1'b0;
            pdSync2 <= 1'b0;
        end else begin
            pdSync1 <= channelPowerdownLow;
            pdSync2 <= pdSync1;
        end
    end

    // receive sampler: the raw level comes from outside, two stages first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxSync1 <= 1'b0;
            rxSync2 <= 1'b0;
        end else begin
            rxSync1 <= lineRxRaw;
            rxSync2 <= rxSync1;
        end
    end

    // receive pair swap: a swapped pair simply inverts the recovered data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lineRxData <= 1'b0;
        end else begin
            // three cycles from pin to output in total
            lineRxData <= rxSync2 ^ lineCtrl.lineRxPairSwap;
        end
    end

    // transmit pair: swapping the legs inverts the differential data;
    // both legs come from flops so they never glitch apart
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lineTxPos <= 1'b0;
            lineTxNeg <= 1'b1;
        end else begin
            lineTxPos <= lineTxData ^ lineCtrl.lineTxPairSwap;
            lineTxNeg <= ~(lineTxData ^ lineCtrl.lineTxPairSwap);
        end
    end

    // first post-cursor: sign on top, four magnitude bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            firstPostTap <= '0;
        end else begin
            // magnitude passes straight through, 2.5 percent per step
            firstPostTap.steps <= lineCtrl.firstPostTapCode[STP_POST1_SIGN_BIT-1:0];
            // minus zero is zero, so the sign only counts with a magnitude
            firstPostTap.negative <= lineCtrl.firstPostTapCode[STP_POST1_SIGN_BIT]
                && (lineCtrl.firstPostTapCode[STP_POST1_SIGN_BIT-1:0] != '0);
        end
    end

    // pre-cursor: sign on top, three magnitude bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            preTap <= '0;
        end else begin
            // top step bit stays clear, the range ends at seven steps
            preTap.steps <= {1'b0, lineCtrl.preTapCode[STP_SHORT_SIGN_BIT-1:0]};
            // minus zero is zero here as well
            preTap.negative <= lineCtrl.preTapCode[STP_SHORT_SIGN_BIT]
                && (lineCtrl.preTapCode[STP_SHORT_SIGN_BIT-1:0] != '0);
        end
    end

    // second post-cursor: same scheme as the pre-cursor
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            secondPostTap <= '0;
        end else begin
            // top step bit stays clear, the range ends at seven steps
            secondPostTap.steps <= {1'b0,
                lineCtrl.secondPostTapCode[STP_SHORT_SIGN_BIT-1:0]};
            // minus zero is zero here as well
            secondPostTap.negative <= lineCtrl.secondPostTapCode[STP_SHORT_SIGN_BIT]
                && (lineCtrl.secondPostTapCode[STP_SHORT_SIGN_BIT-1:0] != '0);
        end
    end

    // pll enable: the power-down sources override the stored enable bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hostPllEnable <= 1'b0;
        end else begin
            // the pin path lags the pin by three cycles, two in the synchroniser and one here
            hostPllEnable <= hostCtrl.hostPllOn && !pllForcedOff;
        end
    end

    // remaining host-side controls: registered copies of the word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hostPllBwSelect <= 2'h0;
            hostPllMultiplier <= 4'h0;
            hostLaneWriteMask <= '0;
        end else begin
            hostPllBwSelect <= hostCtrl.hostPllBwSelect;
            hostPllMultiplier <= hostCtrl.hostPllMultiplier;
            // lane logic downstream applies per-lane writes only where set
            hostLaneWriteMask <= hostCtrl.hostLaneWriteMask[LANES-1:0];
        end
    end

    // read mux; a read of the word being written returns the old value
    always_comb begin
        // unmapped offsets and other devices read as zero
        next_rdData = 16'h0000;
        if (lineHit) begin
            next_rdData = lineCtrl;
        end else if (hostHit) begin
            next_rdData = hostCtrl;
        end
    end

    // read valid: one pulse a cycle after every read, mapped or not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmtRdValid <= 1'b0;
        end else begin
            mgmtRdValid <= mgmtReq.rdEn;
        end
    end

    // read data: captured with the read, then held until the next one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmtRdData <= 16'h0000;
        end else begin
            if (mgmtReq.rdEn) begin
                mgmtRdData <= next_rdData;
            end
        end
    end
endmodule

// [verif/stp_regs_asserts.sv]
// port checks for the register slice
`timescale 1ns/100ps
module stp_regs_asserts
    import stp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // management side
    input wire stp_mgmt_req_type mgmtReq,
    input wire logic [15:0] mgmtRdData,
    input wire logic mgmtRdValid,
    // power, line and taps
    input wire logic channelPowerdownLow,
    input wire logic [15:0] pwrCtrlWord,
    input wire logic lineTxPos,
    input wire logic lineTxNeg,
    input wire stp_tap_type firstPostTap,
    input wire stp_tap_type preTap,
    input wire stp_tap_type secondPostTap,
    input wire logic hostPllEnable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // any read, and a read aimed away from this device
    sequence s_rd; mgmtReq.rdEn; endsequence
    sequence s_stray; s_rd ##0 mgmtReq.devAddr != STP_DEV_ADDR; endsequence
    property p_rdv; s_rd |=> mgmtRdValid; endproperty
    a_rdv: assert property (p_rdv) else $error("read gave no valid");
    property p_stray; s_stray |=> mgmtRdData == 16'h0000; endproperty
    a_stray: assert property (p_stray) else $error("stray read not zero");
    property p_tx; lineTxPos != lineTxNeg; endproperty
    a_tx: assert property (p_tx) else $error("tx pair not complementary");
    property p_pd; pwrCtrlWord[STP_PD_BIT] |=> !hostPllEnable; endproperty
    a_pd: assert property (p_pd) else $error("pll on despite pd bit");
    property p_pin; (!channelPowerdownLow)[*3] |=> !hostPllEnable; endproperty
    a_pin: assert property (p_pin) else $error("pll on despite pin");
    property p_p1; firstPostTap.steps == 4'h0 |-> !firstPostTap.negative; endproperty
    a_p1: assert property (p_p1) else $error("post1 negative zero");
    property p_pre; !preTap.steps[3] && (preTap.steps != 4'h0 || !preTap.negative); endproperty
    a_pre: assert property (p_pre) else $error("pre decode bad");
    property p_p2;
        !secondPostTap.steps[3] && (secondPostTap.steps != 4'h0 || !secondPostTap.negative);
    endproperty
    a_p2: assert property (p_p2) else $error("post2 magnitude too big");
endmodule
bind stp_regs stp_regs_asserts stp_regs_asserts_i (.*);

// [verif/stp_host_model.sv]
// management host model issuing register accesses
`timescale 1ns/100ps
module stp_host_model
    import stp_pkg::*;
(
    // clock
    input wire logic clk,
    // request out, answer in
    output stp_mgmt_req_type mgmtReq,
    input wire logic [15:0] mgmtRdData,
    input wire logic mgmtRdValid
);
    initial mgmtReq = '0;
    // one access; software keeps the reserved line bit set
    task automatic acc(input bit wr, input logic [4:0] dv, input logic [15:0] ofs,
        input logic [15:0] d, output logic [15:0] q, output bit ok);
        ok = wr;
        q = 16'h0000;
        @(posedge clk);
        mgmtReq <= '{wr, !wr, dv, ofs, (ofs == STP_LINE_CTRL_OFS) ? d | 16'h2000 : d};
        @(posedge clk);
        // released lines show a changed value, not the last one
        mgmtReq <= '{1'b0, 1'b0, ~dv, ~ofs, ~d};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = mgmtRdValid === 1'b1;
            q = mgmtRdData;
        end
    endtask
endmodule

// [verif/test_stp_regs.sv]
// self-checking bench for the register slice
`timescale 1ns/100ps
module test_stp_regs import stp_pkg::*;;
    logic clk = 1'b0, arst_n = 1'b0, channelPowerdownLow = 1'b1;
    logic lineRxRaw = 1'b0, lineTxData = 1'b0, lineRxData, lineTxPos, lineTxNeg;
    logic mgmtRdValid, hostPllEnable;
    logic [15:0] pwrCtrlWord = 16'h0000, mgmtRdData, q;
    logic [1:0] hostPllBwSelect;
    logic [3:0] hostPllMultiplier, hostLaneWriteMask;
    stp_mgmt_req_type mgmtReq;
    stp_tap_type firstPostTap, preTap, secondPostTap;
    int err_count = 0, comparisons = 0;
    always #2 clk = ~clk;
    stp_regs stp_regs_i (.*);
    stp_host_model stp_host_model_i (.*);
    // verdict and end of run
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // access through the host; a lost answer ends the run
    task automatic acc(input bit wr, input logic [4:0] dv, input logic [15:0] ofs,
        input logic [15:0] d);
        bit ok;
        stp_host_model_i.acc(wr, dv, ofs, d, q, ok);
        if (!ok) begin
            err_count++;
            report_and_stop();
        end
    endtask
    task automatic t_host(input logic [15:0] e);
        repeat (4) @(posedge clk);
        chk("hostout", e, {hostLaneWriteMask, 2'h0, hostPllBwSelect, 3'h0, hostPllEnable,
            hostPllMultiplier});
    endtask
    // line word: readback, tap decode, pair swaps
    task automatic t_line(input logic [15:0] w, input logic [15:0] taps, input logic b);
        logic [2:0] pins;
        acc(1, STP_DEV_ADDR, STP_LINE_CTRL_OFS, w);
        acc(0, STP_DEV_ADDR, STP_LINE_CTRL_OFS, 16'h0000);
        chk("line", w, q);
        chk("taps", taps, {1'b0, firstPostTap, preTap, secondPostTap});
        lineTxData <= b;
        lineRxRaw <= b;
        // a set swap bit turns the level over, the negative leg is the inverse
        pins = {w[15] ? ~b : b, w[14] ? ~b : b, w[14] ? b : ~b};
        repeat (5) @(posedge clk);
        chk("pins", {13'h0, pins}, {13'h0, lineRxData, lineTxPos, lineTxNeg});
    endtask
    // mid-run reset: every field reloads its default
    task automatic t_reset();
        acc(1, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'h560A);
        repeat (2) @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        acc(0, STP_DEV_ADDR, STP_LINE_CTRL_OFS, 16'h0000);
        chk("rstline", 16'h2000, q);
        acc(0, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'h0000);
        chk("rsthost", 16'hF115, q);
        chk("rsttaps", 16'h0000, {1'b0, firstPostTap, preTap, secondPostTap});
        t_host(16'hF115);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        acc(0, STP_DEV_ADDR, STP_LINE_CTRL_OFS, 16'h0000);
        chk("line", 16'h2000, q);
        acc(0, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'h0000);
        chk("host", 16'hF115, q);
        t_host(16'hF115);
        t_line(16'hFF8F, 16'h7C17, 1'b1);
        t_line(16'h3090, 16'h0220, 1'b1);
        t_line(16'h6A53, 16'h28A3, 1'b0);
        acc(1, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'h560A);
        acc(0, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'h0000);
        chk("host", 16'h560A, q);
        t_host(16'h520A);
        acc(1, STP_DEV_ADDR, STP_HOST_CTRL_OFS, 16'hF115);
        pwrCtrlWord <= 16'h8000;
        t_host(16'hF105);
        pwrCtrlWord <= 16'h0000;
        channelPowerdownLow <= 1'b0;
        t_host(16'hF105);
        channelPowerdownLow <= 1'b1;
        t_host(16'hF115);
        acc(1, STP_DEV_ADDR, 16'h0007, 16'hFFFF);
        acc(0, STP_DEV_ADDR, 16'h0007, 16'h0000);
        chk("stray", 16'h0000, q);
        acc(0, 5'h1F, STP_LINE_CTRL_OFS, 16'h0000);
        chk("otherdev", 16'h0000, q);
        t_reset();
        report_and_stop();
    end
endmodule
